// ==== common/vapc_defs.vh ====
/*
 * constants for the video/audio path configuration register:
 * offsets, field positions, reset values.
 * assumes inclusion by bare name from the design files.
 */
`ifndef VAPC_DEFS_VH
`define VAPC_DEFS_VH

`define VAPC_ADDR_W          8
`define VAPC_DATA_W          8
`define VAPC_OFF_CONFIG      8'h22
`define VAPC_OFF_STATUS      8'h23
`define VAPC_OFF_FWD_SHADOW  8'h24
`define VAPC_CONFIG_RESET    8'h00
`define VAPC_ZERO_BYTE       8'h00
`define VAPC_LOW7_MASK       8'h7f
`define VAPC_BIT_BLOCK       7
`define VAPC_BIT_UNGATED     6
`define VAPC_BIT_POLARITY    5
`define VAPC_BIT_AUD_SUPP    4
`define VAPC_BIT_QUAD_SRC    3
`define VAPC_BIT_DEPTH18     2
`define VAPC_BIT_CARRIAGE    1
`define VAPC_BIT_QUAD_EN     0
`define VAPC_STATE_W         2
`define VAPC_STATUS_USED     4

`endif

// ==== verilog/vapc_fwd_capture.v ====
/*
 * forward-channel capture: holds the last settings word sent by the
 * remote serializer and flags a pending load for one cycle.
 * assumes fwd_valid_i is a one-cycle pulse in the core clock domain.
 */
`timescale 1ns/100ps
`include "vapc_defs.vh"

module vapc_fwd_capture #(
  parameter DATA_W = `VAPC_DATA_W
) (
  input  wire              clk_i,       // core clock
  input  wire              rst_b_i,     // async reset, active low
  input  wire              fwd_valid_i, // forward word strobe
  input  wire [DATA_W-1:0] fwd_data_i,  // forward word
  output reg  [DATA_W-1:0] word_o,      // last received word
  output reg               load_o       // one-cycle load request
);

  // capture word and raise load at the same edge, one cycle after the strobe
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      word_o <= `VAPC_CONFIG_RESET;
      load_o <= 1'b0;
    end
    else
    begin
      load_o <= fwd_valid_i;
      if (fwd_valid_i)
      begin
        word_o <= fwd_data_i;
      end
    end
  end

endmodule

// ==== verilog/vapc_strobe_gate.v ====
/*
 * pixel-valid strobe stage: applies output polarity and gating mode.
 * assumes the incoming strobe is active high and in the core domain.
 */
`timescale 1ns/100ps

module vapc_strobe_gate (
  input  wire clk_i,       // core clock
  input  wire rst_b_i,     // async reset, active low
  input  wire strobe_i,    // raw strobe, active high
  input  wire polarity_i,  // 1 gives active low output
  input  wire ungated_i,   // pass data regardless of strobe
  output reg  strobe_o,    // strobe at chosen polarity
  output reg  data_gate_o  // 1 when pixel data is forwarded
);

  // registered strobe and data gate
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      strobe_o    <= 1'b0;
      data_gate_o <= 1'b0;
    end
    else
    begin
      strobe_o    <= strobe_i ^ polarity_i;
      data_gate_o <= ungated_i | strobe_i;
    end
  end

endmodule

// ==== verilog/vapc_top.v ====
/*
 * video/audio path configuration register with forward-channel loading
 * and the decoded datapath controls it steers.
 * holds: the config register, its forward load path with a per-bit
 * merge, a read-only status word and a shadow of the last forward word,
 * and registered decoded outputs for the pixel and audio datapath.
 * assumes single core clock, synchronous inputs, one-cycle strobes.
 * assumes the forward link delivers whole words as one-cycle pulses,
 * and that software never writes and reads in the same cycle.
 */
// Operation
// - block bit keeps local values, ignores forward
// - lower seven bits loaded from remote
// - ungated bit forwards data ignoring strobe
// - polarity bit: 1 active low strobe
// - suppress bit keeps audio off pixels
// - source-select gates quad enable else off
// - depth bit: 1 is 18-bit, 0 24-bit
// - carriage bit picks in-band or island
// - quad enable bit enables four channels
// - register at 0x22, resets to zero
`timescale 1ns/100ps
`include "vapc_defs.vh"

module vapc_top #(
  parameter ADDR_W = `VAPC_ADDR_W,
  parameter DATA_W = `VAPC_DATA_W
) (
  input  wire              clk_i,            // core clock 50 MHz
  input  wire              rst_b_i,          // async reset, active low
  input  wire [ADDR_W-1:0] addr_i,           // register address
  input  wire [DATA_W-1:0] wdata_i,          // write data
  input  wire              wr_i,             // write strobe
  input  wire              rd_i,             // read strobe
  output reg  [DATA_W-1:0] rdata_o,          // read data, cycle after rd_i
  input  wire              fwd_valid_i,      // forward settings strobe
  input  wire [DATA_W-1:0] fwd_data_i,       // forward settings word
  input  wire              repeater_mode_i,  // device strapped as repeater
  input  wire              strobe_i,         // raw pixel-valid strobe
  output wire              pixel_valid_strobe_o, // strobe at chosen polarity
  output wire              pixel_data_gate_o,    // pixel data forwarded
  output reg               cipher_enable_o,  // content protection allowed
  output reg               audio_on_pixels_o,// packetized audio on pixel bus
  output reg               quad_audio_o,     // four-channel audio active
  output reg               depth_18_o,       // 1: 18-bit, 0: 24-bit
  output reg               carriage_inband_o,// 1: in-band, 0: data island
  output reg               surround_ok_o,    // surround audio supported
  output reg               cfg_conflict_o    // repeater + 18-bit chosen
);

  // configuration register and helpers
  reg  [DATA_W-1:0]        cfg;
  wire [DATA_W-1:0]        next_cfg;
  reg  [DATA_W-1:0]        next_rdata;
  wire [DATA_W-1:0]        status_word;
  reg  [`VAPC_STATE_W-1:0] load_count;
  reg  [`VAPC_STATE_W-1:0] next_count;
  wire [DATA_W-1:0]        fwd_word;
  wire                     fwd_load;
  wire                     fwd_accept;
  wire                     count_full;
  wire                     sel_config;
  wire                     sel_status;
  wire                     sel_shadow;
  wire                     wr_config;
  genvar                   b;

  // named taps on the configuration fields
  wire                     load_block;
  wire                     ungated;
  wire                     aud_supp;
  wire                     quad_src;
  wire                     depth18;
  wire                     carriage;
  wire                     quad_en;

  // next values of the decoded controls
  reg                      next_cipher;
  reg                      next_audio;
  reg                      next_quad;
  reg                      next_depth;
  reg                      next_carriage;
  reg                      next_surround;
  reg                      next_conflict;

  // register decode, exact address match
  assign sel_config = (addr_i == `VAPC_OFF_CONFIG);
  assign sel_status = (addr_i == `VAPC_OFF_STATUS);
  assign sel_shadow = (addr_i == `VAPC_OFF_FWD_SHADOW);
  assign wr_config  = wr_i && sel_config;

  // field taps
  assign load_block = cfg[`VAPC_BIT_BLOCK];
  assign ungated    = cfg[`VAPC_BIT_UNGATED];
  assign aud_supp   = cfg[`VAPC_BIT_AUD_SUPP];
  assign quad_src   = cfg[`VAPC_BIT_QUAD_SRC];
  assign depth18    = cfg[`VAPC_BIT_DEPTH18];
  assign carriage   = cfg[`VAPC_BIT_CARRIAGE];
  assign quad_en    = cfg[`VAPC_BIT_QUAD_EN];

  assign fwd_accept = fwd_load && !load_block;

  // saturation point of the load counter
  assign count_full = &load_count;

  // forward channel word capture
  vapc_fwd_capture #(
    .DATA_W      (DATA_W)
  ) u_fwd (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .fwd_valid_i (fwd_valid_i),
    .fwd_data_i  (fwd_data_i),
    .word_o      (fwd_word),
    .load_o      (fwd_load)
  );

  // next configuration value, one bit at a time; a local write wins
  // over a forward load, and the block bit never comes from afar
  generate
    for (b = 0; b < DATA_W; b = b + 1)
    begin : g_cfg_bit
      if (b == `VAPC_BIT_BLOCK)
      begin : g_local
        assign next_cfg[b] = wr_config ? wdata_i[b] : cfg[b];
      end
      else
      begin : g_shared
        assign next_cfg[b] = wr_config  ? wdata_i[b]  :
                             fwd_accept ? fwd_word[b] : cfg[b];
      end
    end
  endgenerate

  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cfg <= `VAPC_CONFIG_RESET;
    end
    else
    begin
      cfg <= next_cfg;
    end
  end

  // next load count, saturating so it never wraps to zero
  always @*
  begin
    next_count = load_count;
    if (fwd_accept && !count_full)
    begin
      next_count = load_count + 1'b1;
    end
  end

  // count of accepted forward loads, readable in the status word
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      load_count <= {`VAPC_STATE_W{1'b0}};
    end
    else
    begin
      load_count <= next_count;
    end
  end

  // status word: count of accepted loads, conflict flag, strap
  assign status_word = {{(DATA_W-`VAPC_STATUS_USED){1'b0}}, load_count, cfg_conflict_o,
                        repeater_mode_i};

  // read data mux: the addressed register while rd_i, else zero
  always @*
  begin
    next_rdata = `VAPC_ZERO_BYTE;
    if (rd_i && sel_config)
    begin
      next_rdata = cfg;
    end
    else if (rd_i && sel_status)
    begin
      next_rdata = status_word;
    end
    else if (rd_i && sel_shadow)
    begin
      next_rdata = fwd_word;
    end
  end

  // read port: data in the cycle after rd_i, then back to zero
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rdata_o <= `VAPC_ZERO_BYTE;
    end
    else
    begin
      rdata_o <= next_rdata;
    end
  end

  vapc_strobe_gate u_strobe (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .strobe_i    (strobe_i),
    .polarity_i  (cfg[`VAPC_BIT_POLARITY]),
    .ungated_i   (ungated),
    .strobe_o    (pixel_valid_strobe_o),
    .data_gate_o (pixel_data_gate_o)
  );

  // decoded datapath controls from the configuration fields
  always @*
  begin
    next_cipher   = !ungated;
    next_audio    = !aud_supp && !ungated;
    next_quad     = quad_src && quad_en;
    next_depth    = depth18;
    next_carriage = carriage;
    next_surround = !(repeater_mode_i && depth18);
    next_conflict = repeater_mode_i && depth18;
  end

  // cipher permission flop
  // low while pixels pass ungated
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cipher_enable_o <= 1'b0;
    end
    else
    begin
      cipher_enable_o <= next_cipher;
    end
  end

  // audio-on-pixels flop
  // low when suppressed or ungated
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      audio_on_pixels_o <= 1'b0;
    end
    else
    begin
      audio_on_pixels_o <= next_audio;
    end
  end

  // four-channel audio flop
  // off unless source select is set
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      quad_audio_o <= 1'b0;
    end
    else
    begin
      quad_audio_o <= next_quad;
    end
  end

  // colour depth flop
  // high selects the narrow pixel format
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      depth_18_o <= 1'b0;
    end
    else
    begin
      depth_18_o <= next_depth;
    end
  end

  // audio carriage flop
  // high selects in-band transport
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      carriage_inband_o <= 1'b0;
    end
    else
    begin
      carriage_inband_o <= next_carriage;
    end
  end

  // surround support flop
  // low for repeater with narrow pixels
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      surround_ok_o <= 1'b0;
    end
    else
    begin
      surround_ok_o <= next_surround;
    end
  end

  // conflict flag flop
  // software reads it in the status word
  always @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cfg_conflict_o <= 1'b0;
    end
    else
    begin
      cfg_conflict_o <= next_conflict;
    end
  end

endmodule

// ==== sim/vapc_chk.sv ====
/* checker for vapc_top: output relations seen at its ports.
   assumes one core clock; bound to vapc_top below. */
`timescale 1ns/100ps
`include "vapc_defs.vh"
module vapc_chk (
  input wire       clk_i,                // clock
  input wire       rst_b_i,              // reset
  input wire [7:0] addr_i,               // address
  input wire       rd_i,                 // read
  input wire [7:0] rdata_o,              // read data
  input wire       repeater_mode_i,      // strap
  input wire       strobe_i,             // raw strobe
  input wire       pixel_valid_strobe_o, // strobe out
  input wire       pixel_data_gate_o,    // gate
  input wire       cipher_enable_o,      // cipher
  input wire       audio_on_pixels_o,    // audio
  input wire       quad_audio_o,         // quad
  input wire       depth_18_o,           // depth
  input wire       carriage_inband_o,    // carriage
  input wire       surround_ok_o,        // surround
  input wire       cfg_conflict_o        // conflict
);
  reg live;   // past first edge
  reg cfg_rd; // rdata_o holds config
  // rdata_o and decoded outputs sample cfg at the same edge
  always @(posedge clk_i or negedge rst_b_i)
    if (!rst_b_i)
    begin
      live   <= 1'b0;
      cfg_rd <= 1'b0;
    end
    else
    begin
      live   <= 1'b1;
      cfg_rd <= rd_i && (addr_i == `VAPC_OFF_CONFIG);
    end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  rd_zero_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
    else $error("stray read data");
  reset_dec_a: assert property ($rose(live) |-> cipher_enable_o && audio_on_pixels_o)
    else $error("bad decode after reset");
  strobe_pol_a: assert property (cfg_rd |-> pixel_valid_strobe_o == ($past(strobe_i) ^ rdata_o[5]))
    else $error("strobe polarity wrong");
  data_gate_a: assert property (cfg_rd |-> pixel_data_gate_o == ($past(strobe_i) | rdata_o[6]))
    else $error("data gate wrong");
  cipher_off_a: assert property (cfg_rd |-> cipher_enable_o == !rdata_o[6])
    else $error("cipher enable wrong");
  audio_supp_a: assert property (cfg_rd |-> audio_on_pixels_o == !(rdata_o[4] | rdata_o[6]))
    else $error("audio on pixels wrong");
  quad_gate_a: assert property (cfg_rd |-> quad_audio_o == (rdata_o[3] & rdata_o[0]))
    else $error("quad audio wrong");
  depth_sel_a: assert property (cfg_rd |-> depth_18_o == rdata_o[2])
    else $error("depth wrong");
  carriage_sel_a: assert property (cfg_rd |-> carriage_inband_o == rdata_o[1])
    else $error("carriage wrong");
  surround_pair_a: assert property (cfg_rd |-> cfg_conflict_o == ($past(repeater_mode_i) & rdata_o[2]) && surround_ok_o == !cfg_conflict_o)
    else $error("surround flags wrong");
  cover property (cfg_rd && rdata_o[7]);
  cover property (cfg_rd && cfg_conflict_o);
  cover property (cfg_rd && quad_audio_o);
endmodule
bind vapc_top vapc_chk u_chk (.*);

// ==== sim/vapc_remote.sv ====
/* remote serializer: sends settings words on the forward link.
   assumes the core clock; a word is a one-cycle strobe. */
`timescale 1ns/100ps
module vapc_remote (
  input  wire       clk_i,       // clock
  output reg        fwd_valid_o, // strobe
  output reg  [7:0] fwd_data_o   // word
);
  initial fwd_valid_o = 1'b0;
  initial fwd_data_o = 8'h00;
  task send(input [7:0] w);
    begin
      @(posedge clk_i);
      fwd_valid_o <= 1'b1;
      fwd_data_o  <= w;
      @(posedge clk_i);
      fwd_valid_o <= 1'b0;
      fwd_data_o  <= ~w; // stale data inverted
    end
  endtask
endmodule

// ==== sim/video_audio_path_config_bench.sv ====
/* bench for vapc_top: register bus, forward loads, decoded outputs.
   assumes vapc_remote on the forward link. */
`timescale 1ns/100ps
module video_audio_path_config_bench;
  reg        clk_i    = 1'b0;  // clock
  reg        rst_b_i  = 1'b0;  // reset
  reg  [7:0] addr_i   = 8'h00; // address
  reg  [7:0] wdata_i  = 8'h00; // write data
  reg        wr_i     = 1'b0;  // write
  reg        rd_i     = 1'b0;  // read
  reg        rep_i    = 1'b0;  // strap
  reg        strobe_i = 1'b0;  // raw strobe
  reg  [7:0] d;                // read value
  wire [7:0] rdata_o, fwd_data;
  wire       fwd_valid;
  wire [8:0] dec;              // decoded outputs
  integer    errors = 0;
  integer    num_checks = 0;
  integer    i;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) strobe_i <= ~strobe_i;
  vapc_top u_dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .fwd_valid_i(fwd_valid),
    .fwd_data_i(fwd_data), .repeater_mode_i(rep_i), .strobe_i(strobe_i),
    .pixel_valid_strobe_o(dec[8]), .pixel_data_gate_o(dec[7]), .cipher_enable_o(dec[6]),
    .audio_on_pixels_o(dec[5]), .quad_audio_o(dec[4]), .depth_18_o(dec[3]),
    .carriage_inband_o(dec[2]), .surround_ok_o(dec[1]), .cfg_conflict_o(dec[0]));
  vapc_remote u_rem (.clk_i(clk_i), .fwd_valid_o(fwd_valid), .fwd_data_o(fwd_data));
  task chk(input [63:0] name, input [7:0] seen, input [7:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        errors = errors + 1;
        $display("mismatch %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= v;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i    <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i   <= 1'b0;
      #1 d = rdata_o;
    end
  endtask
  // expected decode: cipher, audio, quad, depth, carriage, surround, conflict
  function [7:0] dec_exp(input [7:0] e);
    dec_exp = {1'b0, ~e[6], ~e[4] & ~e[6], e[3] & e[0], e[2], e[1],
      ~(rep_i & e[2]), rep_i & e[2]};
  endfunction
  task look(input [7:0] e);
    begin
      rd(8'h22);
      chk("config", d, e);
      chk("decoded", {1'b0, dec[6:0]}, dec_exp(e));
    end
  endtask
  task t_fields;
    for (i = 0; i < 16; i = i + 1)
    begin
      if (i == 8)
      begin
        @(posedge clk_i);
        rep_i <= 1'b1;
      end
      wr(8'h22, (8'h01 << (i % 8)) | ((i > 7) ? 8'h09 : 8'h00));
      look((8'h01 << (i % 8)) | ((i > 7) ? 8'h09 : 8'h00));
    end
  endtask
  task t_fwd;
    begin
      wr(8'h22, 8'h00);
      u_rem.send(8'hff);
      look(8'h7f);
      wr(8'h22, 8'h80);
      u_rem.send(8'h55);
      look(8'h80);
      wr(8'h22, 8'h00);
      u_rem.send(8'h2a);
      look(8'h2a);
      wr(8'h30, 8'hff);
      rd(8'h30);
      chk("unmapped", d, 8'h00);
      rd(8'h23);
      chk("status", d, 8'h09);
      rd(8'h24);
      chk("shadow", d, 8'h2a);
      look(8'h2a);
      $display("test forward done");
    end
  endtask
  task t_reset;
    begin
      @(posedge clk_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      rst_b_i <= 1'b1;
      look(8'h00);
      rd(8'h23);
      chk("status", d, 8'h01);
      rd(8'h24);
      chk("shadow", d, 8'h00);
      $display("test mid-run reset done");
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_b_i <= 1'b1;
    look(8'h00);
    $display("test reset done");
    t_fields;
    $display("test fields done");
    t_fwd;
    t_reset;
    stop_test;
  end
  initial
  begin
    #100000;
    errors = errors + 1;
    stop_test;
  end
endmodule
